// ===== usf_bit_timer.sv
`timescale 1ns/1ps
module usf_bit_timer
    import usf_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Control
    input  wire logic        en,
    input  wire logic        restart,
    input  wire logic        half,
    input  wire logic [15:0] div_int,
    input  wire logic [2:0]  div_frac,
    // Bit boundary
    output logic             tick
);

    typedef struct packed {
        logic [15:0] cnt;
        logic [2:0]  acc;
        logic        tick;
    } usf_tmr_t;

    usf_tmr_t    s;
    usf_tmr_t    n;
    logic [15:0] di;
    logic [3:0]  sum;
    logic [15:0] hp;

    // ====================
    // Divisor clamp
    assign di  = (div_int < DIV_MIN) ? DIV_MIN : (div_int > DIV_MAX) ? DIV_MAX : div_int;
    assign sum = {1'b0, s.acc} + {1'b0, div_frac};
    assign hp  = di >> 1;

    always_comb begin
        n      = s;
        n.tick = 1'b0;
        if (rst) begin
            n = '0;
        end else if (!en) begin
            n.cnt = '0;
            n.acc = '0;
        end else if (restart) begin
            n.cnt = half ? hp : di - 16'h0001;
            n.acc = '0;
        end else if (s.cnt <= 16'h0001) begin
            n.tick = 1'b1;
            n.cnt  = di + {15'h0000, sum[3]};
            n.acc  = sum[2:0];
        end else begin
            n.cnt = s.cnt - 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        s <= n;
    end

    assign tick = s.tick;

endmodule

// ===== usf_partner.sv
`timescale 1ns/1ps
module usf_partner (
    // Clock
    input wire logic        clk,
    // Serial lines
    input wire logic        txd,
    output logic            rxd,
    // Frame shape
    input wire logic [15:0] per,
    input wire logic [3:0]  nbits
);
    logic [11:0] got;
    int          ncap = 0;
    initial rxd = 1'b1;
    // ====================
    // Capture frame
    always @(negedge txd) begin
        for (int i = 0; i <= nbits + 1; i++) begin
            repeat (i ? per : per / 2) @(posedge clk);
            got[i] = txd;
        end
        ncap++;
    end
    // ====================
    // Send frame
    task automatic send(input logic [8:0] d, input int n);
        for (int i = 0; i <= n + 1; i++) begin
            rxd <= (i == 0) ? 1'b0 : (i > n) ? 1'b1 : d[i-1];
            repeat (per) @(posedge clk);
        end
    endtask
endmodule

// ===== usf_pkg.sv
package usf_pkg;

    // ====================
    // Register offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_BAUD   = 8'h04;
    localparam logic [7:0] ADDR_TXDATA = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_RXDATA = 8'h10;
    localparam logic [7:0] ADDR_XCHAR  = 8'h14;

    // ====================
    // Control register layout
    localparam int CTRL_W         = 10;
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_FLOW_LSB  = 1;
    localparam int CTRL_DATA8_BIT = 4;
    localparam int CTRL_PAR_LSB   = 5;
    localparam int CTRL_STOP2_BIT = 8;
    localparam int CTRL_DTR_BIT   = 9;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h219;

    // ====================
    // Baud divisor layout
    localparam int BAUD_W        = 19;
    localparam int BAUD_FRAC_LSB = 0;
    localparam int BAUD_INT_LSB  = 3;
    localparam logic [BAUD_W-1:0] BAUD_RESET = 19'h00180;
    localparam logic [15:0] DIV_MIN = 16'h0004;
    localparam logic [15:0] DIV_MAX = 16'h9c40;

    // ====================
    // Flow control characters
    localparam logic [15:0] XCHAR_RESET = 16'h1311;

    // ====================
    // Status bits cleared by one
    localparam int ST_OVR_BIT   = 4;
    localparam int ST_PERR_BIT  = 5;
    localparam int ST_FERR_BIT  = 6;
    localparam int ST_TDROP_BIT = 14;

    // ====================
    // Synchroniser lanes
    localparam int SYN_RXD  = 0;
    localparam int SYN_CTS  = 1;
    localparam int SYN_DSR  = 2;
    localparam int SYN_DCD  = 3;
    localparam int SYN_RI   = 4;
    localparam int SYN_CFG0 = 5;

    // ====================
    // Pin configuration codes
    localparam logic [1:0] CFG_BUS_ONLY    = 2'h1;
    localparam logic [1:0] CFG_SERIAL_ONLY = 2'h2;

    // ====================
    // Modes and states
    typedef enum logic [2:0] {
        FLOW_OFF, FLOW_RTS_CTS, FLOW_DTR_DSR, FLOW_XON_XOFF, FLOW_NONE
    } usf_flow_t;

    typedef enum logic [2:0] {
        PAR_NONE, PAR_ODD, PAR_EVEN, PAR_MARK, PAR_SPACE
    } usf_par_t;

    typedef enum logic [2:0] {
        TX_IDLE, TX_PRE, TX_START, TX_DATA, TX_PAR, TX_STOP
    } usf_tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
    } usf_rx_state_t;

    typedef struct packed {
        logic [16:0] rsvd;
        logic        tx_drop;
        logic [1:0]  cfg;
        logic        ri;
        logic        dcd;
        logic        dsr;
        logic        cts;
        logic        xoff;
        logic        ferr;
        logic        perr;
        logic        ovr;
        logic        rx_reg_full;
        logic        rx_hold_full;
        logic        tx_act;
        logic        tx_hold_full;
    } usf_status_t;

endpackage

// ===== usf_uart.sv
//
// Functional notes
// - Strap pins pick bus-only (serial off), serial-only or combined pin map.
// - Transmit-active leads start bit by one clock, ends with stop.
// - Frame: start, 7 or 8 data, optional parity, 1 or 2 stops.
// - Odd or even parity over the ones count.
// - Parity may be absent, fixed high or fixed low.
// - Data bits least significant first.
// - Flow modes: off to GPIO, RTS/CTS, DTR/DSR, XON/XOFF, none.
// - RTS/CTS: new character only while clear-to-send low.
// - RTS/CTS: request-to-send high when both receive stores full.
// - DTR/DSR: no sending while set-ready high.
// - Terminal-ready asserted from reset; control bit may change it.
// - Low terminal-ready means ready to receive.
// - XON resumes, XOFF stops sending; defaults 11 and 13.
// - Bit period 4 to 40000 clocks.
// - First digital pin carries transmit-active for RS485.
// - Serial off returns its pins to GPIO.
// - Divisor has an eighths fraction.
//
`timescale 1ns/1ps
module usf_uart
    import usf_pkg::*;
(
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Serial pins
    input  wire logic        RXD,
    output logic             TXD,
    input  wire logic        CLEAR_TO_SEND_N,
    output logic             REQUEST_TO_SEND_N,
    input  wire logic        SET_READY_N,
    output logic             TERMINAL_READY_N,
    input  wire logic        CARRIER_DETECT,
    input  wire logic        CALL_ALERT_IN,
    output logic             FIRST_DIGITAL_PIN,
    // Pin configuration
    input  wire logic        CFG_SELECT0,
    input  wire logic        CFG_SELECT1,
    output logic             PIN_GPIO_MODE,
    output logic             PIN_MAP_COMBINED
);

    typedef struct packed {
        logic [6:0]        syn1;
        logic [6:0]        syn2;
        logic              rxd_prev;
        logic [CTRL_W-1:0] ctrl;
        logic [BAUD_W-1:0] baud;
        logic [15:0]       xchar;
        logic              pready;
        logic              pslverr;
        logic              rd_pop;
        logic [31:0]       prdata;
        logic [7:0]        tx_hold;
        logic              tx_hold_full;
        usf_tx_state_t     tx_state;
        logic [7:0]        tx_sh;
        logic              tx_par;
        logic [2:0]        tx_cnt;
        logic              txd;
        logic              tx_act;
        usf_rx_state_t     rx_state;
        logic [7:0]        rx_sh;
        logic              rx_par;
        logic [2:0]        rx_cnt;
        logic              rx_ferr;
        logic [7:0]        rx_hold;
        logic [7:0]        rx_reg;
        logic              rx_hold_full;
        logic              rx_reg_full;
        logic              ovr;
        logic              perr;
        logic              ferr;
        logic              tdrop;
        logic              xoff_act;
        logic              o_txd;
        logic              o_rts_n;
        logic              o_dtr_n;
        logic              o_first_digital_pin;
        logic              o_gpio;
        logic              o_comb;
    } usf_state_t;

    usf_state_t  s;
    usf_state_t  n;
    usf_flow_t   flow;
    usf_par_t    par;
    usf_status_t status_w;
    logic [1:0]  cfg;
    logic [2:0]  last_bit;
    logic [7:0]  rx_char;
    logic        data8;
    logic        stop2;
    logic        sr_on;
    logic        tx_go;
    logic        rxd;
    logic        tx_tick;
    logic        rx_tick;
    logic        apb_wr;
    logic        apb_rd;
    logic        rx_done;

    // ====================
    // Parity bit for a character
    function automatic logic par_bit(input usf_par_t p, input logic [7:0] d);
        case (p)
            PAR_ODD:  par_bit = ~^d;
            PAR_EVEN: par_bit = ^d;
            PAR_MARK: par_bit = 1'b1;
            default:  par_bit = 1'b0;
        endcase
    endfunction

    // ====================
    // Decodes
    assign flow     = usf_flow_t'(s.ctrl[CTRL_FLOW_LSB +: 3]);
    assign par      = usf_par_t'(s.ctrl[CTRL_PAR_LSB +: 3]);
    assign data8    = s.ctrl[CTRL_DATA8_BIT];
    assign stop2    = s.ctrl[CTRL_STOP2_BIT];
    assign last_bit = data8 ? 3'h7 : 3'h6;
    assign cfg      = s.syn2[SYN_CFG0 +: 2];
    assign rxd      = s.syn2[SYN_RXD];
    assign sr_on    = s.ctrl[CTRL_EN_BIT] && flow != FLOW_OFF && cfg != CFG_BUS_ONLY;
    assign rx_char  = data8 ? s.rx_sh : {1'b0, s.rx_sh[7:1]};
    assign apb_wr   = PSEL && PENABLE && s.pready && PWRITE;
    assign apb_rd   = PSEL && PENABLE && s.pready && !PWRITE;

    // Flow gate on a new character
    assign tx_go = s.tx_hold_full && sr_on &&
                   (flow != FLOW_RTS_CTS  || !s.syn2[SYN_CTS]) &&
                   (flow != FLOW_DTR_DSR  || !s.syn2[SYN_DSR]) &&
                   (flow != FLOW_XON_XOFF || !s.xoff_act);

    always_comb begin
        status_w              = '0;
        status_w.tx_hold_full = s.tx_hold_full;
        status_w.tx_act       = s.tx_act;
        status_w.rx_hold_full = s.rx_hold_full;
        status_w.rx_reg_full  = s.rx_reg_full;
        status_w.ovr          = s.ovr;
        status_w.perr         = s.perr;
        status_w.ferr         = s.ferr;
        status_w.xoff         = s.xoff_act;
        status_w.cts          = !s.syn2[SYN_CTS];
        status_w.dsr          = !s.syn2[SYN_DSR];
        status_w.dcd          = s.syn2[SYN_DCD];
        status_w.ri           = s.syn2[SYN_RI];
        status_w.cfg          = cfg;
        status_w.tx_drop      = s.tdrop;
    end

    // ====================
    // Bit timers
    usf_bit_timer u_tx_tmr (
        .clk      (SYS_CLK),
        .rst      (RST),
        .en       (s.tx_state != TX_IDLE),
        .restart  (s.tx_state == TX_PRE),
        .half     (1'b0),
        .div_int  (s.baud[BAUD_INT_LSB +: 16]),
        .div_frac (s.baud[BAUD_FRAC_LSB +: 3]),
        .tick     (tx_tick)
    );

    usf_bit_timer u_rx_tmr (
        .clk      (SYS_CLK),
        .rst      (RST),
        .en       (1'b1),
        .restart  (s.rx_state == RX_IDLE),
        .half     (1'b1),
        .div_int  (s.baud[BAUD_INT_LSB +: 16]),
        .div_frac (s.baud[BAUD_FRAC_LSB +: 3]),
        .tick     (rx_tick)
    );

    // ====================
    // Next state
    always_comb begin
        n         = s;
        rx_done   = 1'b0;
        n.syn1    = {CFG_SELECT1, CFG_SELECT0, CALL_ALERT_IN, CARRIER_DETECT,
                     SET_READY_N, CLEAR_TO_SEND_N, RXD};
        n.syn2    = s.syn1;
        n.rxd_prev = rxd;
        n.pready  = 1'b0;
        n.pslverr = 1'b0;
        n.rd_pop  = 1'b0;

        // APB setup
        if (PSEL && !PENABLE) begin
            n.pready = 1'b1;
            n.prdata = '0;
            case (PADDR)
                ADDR_CTRL:   n.prdata = {22'h000000, s.ctrl};
                ADDR_BAUD:   n.prdata = {13'h0000, s.baud};
                ADDR_TXDATA: n.prdata = {24'h000000, s.tx_hold};
                ADDR_STATUS: n.prdata = status_w;
                ADDR_RXDATA: begin
                    n.prdata = {23'h000000, s.rx_hold_full, s.rx_hold};
                    n.rd_pop = s.rx_hold_full;
                end
                ADDR_XCHAR:  n.prdata = {16'h0000, s.xchar};
                default:     n.pslverr = 1'b1;
            endcase
        end

        // APB access phase
        if (apb_wr) begin
            case (PADDR)
                ADDR_CTRL:   n.ctrl = PWDATA[CTRL_W-1:0];
                ADDR_BAUD:   n.baud = PWDATA[BAUD_W-1:0];
                ADDR_XCHAR:  n.xchar = PWDATA[15:0];
                ADDR_TXDATA: begin
                    if (!s.tx_hold_full) begin
                        n.tx_hold      = PWDATA[7:0];
                        n.tx_hold_full = 1'b1;
                    end else begin
                        n.tdrop = 1'b1;
                    end
                end
                ADDR_STATUS: begin
                    if (PWDATA[ST_OVR_BIT])   n.ovr   = 1'b0;
                    if (PWDATA[ST_PERR_BIT])  n.perr  = 1'b0;
                    if (PWDATA[ST_FERR_BIT])  n.ferr  = 1'b0;
                    if (PWDATA[ST_TDROP_BIT]) n.tdrop = 1'b0;
                end
                default: ;
            endcase
        end
        if (apb_rd && PADDR == ADDR_RXDATA && s.rd_pop) begin
            n.rx_hold      = s.rx_reg;
            n.rx_hold_full = s.rx_reg_full;
            n.rx_reg_full  = 1'b0;
        end

        // Transmitter
        case (s.tx_state)
            TX_IDLE: begin
                if (tx_go) begin
                    n.tx_state     = TX_PRE;
                    n.tx_act       = 1'b1;
                    n.tx_sh        = s.tx_hold;
                    n.tx_par       = par_bit(par, data8 ? s.tx_hold : {1'b0, s.tx_hold[6:0]});
                    n.tx_hold_full = 1'b0;
                end
            end
            TX_PRE: begin
                n.tx_state = TX_START;
                n.txd      = 1'b0;
            end
            TX_START: begin
                if (tx_tick) begin
                    n.tx_state = TX_DATA;
                    n.txd      = s.tx_sh[0];
                    n.tx_sh    = s.tx_sh >> 1;
                    n.tx_cnt   = '0;
                end
            end
            TX_DATA: begin
                if (tx_tick) begin
                    if (s.tx_cnt == last_bit) begin
                        n.tx_state = (par == PAR_NONE) ? TX_STOP : TX_PAR;
                        n.txd      = (par == PAR_NONE) ? 1'b1 : s.tx_par;
                        n.tx_cnt   = '0;
                    end else begin
                        n.txd    = s.tx_sh[0];
                        n.tx_sh  = s.tx_sh >> 1;
                        n.tx_cnt = s.tx_cnt + 3'h1;
                    end
                end
            end
            TX_PAR: begin
                if (tx_tick) begin
                    n.tx_state = TX_STOP;
                    n.txd      = 1'b1;
                end
            end
            TX_STOP: begin
                if (tx_tick) begin
                    if (stop2 && s.tx_cnt == 3'h0) begin
                        n.tx_cnt = 3'h1;
                    end else begin
                        n.tx_state = TX_IDLE;
                        n.tx_act   = 1'b0;
                    end
                end
            end
            default: begin
                n.tx_state = TX_IDLE;
                n.txd      = 1'b1;
                n.tx_act   = 1'b0;
            end
        endcase

        // Receiver
        case (s.rx_state)
            RX_IDLE: begin
                if (sr_on && s.rxd_prev && !rxd) begin
                    n.rx_state = RX_START;
                    n.rx_ferr  = 1'b0;
                end
            end
            RX_START: begin
                if (rx_tick) begin
                    n.rx_state = rxd ? RX_IDLE : RX_DATA;
                    n.rx_cnt   = '0;
                end
            end
            RX_DATA: begin
                if (rx_tick) begin
                    n.rx_sh = {rxd, s.rx_sh[7:1]};
                    if (s.rx_cnt == last_bit) begin
                        n.rx_state = (par == PAR_NONE) ? RX_STOP : RX_PAR;
                        n.rx_cnt   = '0;
                    end else begin
                        n.rx_cnt = s.rx_cnt + 3'h1;
                    end
                end
            end
            RX_PAR: begin
                if (rx_tick) begin
                    n.rx_par   = rxd;
                    n.rx_state = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_tick) begin
                    if (!rxd) n.rx_ferr = 1'b1;
                    if (stop2 && s.rx_cnt == 3'h0) begin
                        n.rx_cnt = 3'h1;
                    end else begin
                        n.rx_state = RX_IDLE;
                        rx_done    = 1'b1;
                    end
                end
            end
            default: n.rx_state = RX_IDLE;
        endcase

        // Character delivery, set wins
        if (rx_done) begin
            if (n.rx_ferr) n.ferr = 1'b1;
            if (par != PAR_NONE && s.rx_par != par_bit(par, rx_char)) n.perr = 1'b1;
            if (flow == FLOW_XON_XOFF && rx_char == s.xchar[7:0]) begin
                n.xoff_act = 1'b0;
            end else if (flow == FLOW_XON_XOFF && rx_char == s.xchar[15:8]) begin
                n.xoff_act = 1'b1;
            end else if (!n.rx_hold_full) begin
                n.rx_hold      = rx_char;
                n.rx_hold_full = 1'b1;
            end else if (!n.rx_reg_full) begin
                n.rx_reg      = rx_char;
                n.rx_reg_full = 1'b1;
            end else begin
                n.ovr = 1'b1;
            end
        end
        if (flow != FLOW_XON_XOFF) n.xoff_act = 1'b0;

        // Serial off
        if (!sr_on) begin
            n.tx_state = TX_IDLE;
            n.tx_act   = 1'b0;
            n.txd      = 1'b1;
            n.rx_state = RX_IDLE;
        end

        // Registered pin outputs
        n.o_txd   = sr_on ? n.txd : 1'b1;
        n.o_first_digital_pin  = n.tx_act;
        n.o_rts_n = !sr_on || (flow == FLOW_RTS_CTS && n.rx_hold_full && n.rx_reg_full);
        n.o_dtr_n = !sr_on || !n.ctrl[CTRL_DTR_BIT];
        n.o_gpio  = !sr_on;
        n.o_comb  = cfg != CFG_SERIAL_ONLY && cfg != CFG_BUS_ONLY;

        if (RST) begin
            n         = '0;
            n.ctrl    = CTRL_RESET;
            n.baud    = BAUD_RESET;
            n.xchar   = XCHAR_RESET;
            n.txd     = 1'b1;
            n.o_txd   = 1'b1;
            n.o_rts_n = 1'b1;
            n.o_dtr_n = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        s <= n;
    end

    // ====================
    // Outputs
    assign PRDATA            = s.prdata;
    assign PREADY            = s.pready;
    assign PSLVERR           = s.pslverr;
    assign TXD               = s.o_txd;
    assign REQUEST_TO_SEND_N = s.o_rts_n;
    assign TERMINAL_READY_N  = s.o_dtr_n;
    assign FIRST_DIGITAL_PIN = s.o_first_digital_pin;
    assign PIN_GPIO_MODE     = s.o_gpio;
    assign PIN_MAP_COMBINED  = s.o_comb;

endmodule

// ===== usf_uart_assertions.sv
`timescale 1ns/1ps
module usf_uart_checker (
    // Clock and reset
    input wire logic        SYS_CLK,
    input wire logic        RST,
    // Register bus
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [31:0] PRDATA,
    // Serial pins
    input wire logic        TXD,
    input wire logic        REQUEST_TO_SEND_N,
    input wire logic        TERMINAL_READY_N,
    input wire logic        FIRST_DIGITAL_PIN,
    // Pin configuration
    input wire logic        CFG_SELECT0,
    input wire logic        CFG_SELECT1,
    input wire logic        PIN_GPIO_MODE,
    input wire logic        PIN_MAP_COMBINED
);
    // ====================
    // Properties
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    property p_idle_high; !FIRST_DIGITAL_PIN |-> TXD; endproperty
    property p_tx_lead; $rose(FIRST_DIGITAL_PIN) |-> TXD ##1 !TXD; endproperty
    property p_tx_tail; $fell(FIRST_DIGITAL_PIN) |-> TXD && $past(TXD); endproperty
    property p_apb_ready; PSEL && $rose(PENABLE) |-> PREADY ##1 !PREADY; endproperty
    property p_apb_err; PSLVERR |-> PREADY && PRDATA == 32'h0; endproperty
    property p_gpio_pins;
        PIN_GPIO_MODE |-> TXD && REQUEST_TO_SEND_N && TERMINAL_READY_N;
    endproperty
    property p_cfg_comb; (CFG_SELECT0 == CFG_SELECT1) [*5] |-> PIN_MAP_COMBINED; endproperty
    property p_cfg_ser; (CFG_SELECT1 && !CFG_SELECT0) [*5] |-> !PIN_MAP_COMBINED; endproperty
    property p_dtr_reset; $past(RST) |-> !TERMINAL_READY_N; endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("serial out low while idle");
    a_tx_lead: assert property (p_tx_lead)
        else $error("start bit not one cycle after active");
    a_tx_tail: assert property (p_tx_tail)
        else $error("active fell outside stop bit");
    a_apb_ready: assert property (p_apb_ready)
        else $error("ready not a one cycle pulse");
    a_apb_err: assert property (p_apb_err)
        else $error("error response without ready or with data");
    a_gpio_pins: assert property (p_gpio_pins)
        else $error("serial pins driven while off");
    a_cfg_comb: assert property (p_cfg_comb)
        else $error("combined mapping missing");
    a_cfg_ser: assert property (p_cfg_ser)
        else $error("serial only mapping missing");
    a_dtr_reset: assert property (p_dtr_reset)
        else $error("terminal ready not asserted after reset");
    c_tx: cover property ($rose(FIRST_DIGITAL_PIN));
    c_err: cover property (PSLVERR);
    c_rts: cover property ($rose(REQUEST_TO_SEND_N));
endmodule

bind usf_uart usf_uart_checker usf_uart_checker_i (
    .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PRDATA(PRDATA), .TXD(TXD), .REQUEST_TO_SEND_N(REQUEST_TO_SEND_N),
    .TERMINAL_READY_N(TERMINAL_READY_N), .FIRST_DIGITAL_PIN(FIRST_DIGITAL_PIN),
    .CFG_SELECT0(CFG_SELECT0), .CFG_SELECT1(CFG_SELECT1), .PIN_GPIO_MODE(PIN_GPIO_MODE),
    .PIN_MAP_COMBINED(PIN_MAP_COMBINED));

// ===== usf_uart_test.sv
`timescale 1ns/1ps
module usf_uart_test;
    import usf_pkg::*;
    logic        SYS_CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [7:0]  PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA, rd;
    logic        PREADY, PSLVERR, err, RXD, TXD, REQUEST_TO_SEND_N, TERMINAL_READY_N;
    logic        FIRST_DIGITAL_PIN, PIN_GPIO_MODE, PIN_MAP_COMBINED;
    logic        CLEAR_TO_SEND_N = 1, SET_READY_N = 1, CARRIER_DETECT = 1, CALL_ALERT_IN = 0;
    logic        CFG_SELECT0 = 0, CFG_SELECT1 = 0;
    logic [3:0]  nbits = 8;
    logic [9:0]  fr [7] = '{10'h219, 10'h239, 10'h259, 10'h279, 10'h299, 10'h309, 10'h329};
    int          err_total = 0, n_compared = 0, n0;

    always #5 SYS_CLK = ~SYS_CLK;

    usf_uart usf_uart_i (
        .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .RXD(RXD), .TXD(TXD), .CLEAR_TO_SEND_N(CLEAR_TO_SEND_N),
        .REQUEST_TO_SEND_N(REQUEST_TO_SEND_N), .SET_READY_N(SET_READY_N),
        .TERMINAL_READY_N(TERMINAL_READY_N), .CARRIER_DETECT(CARRIER_DETECT),
        .CALL_ALERT_IN(CALL_ALERT_IN), .FIRST_DIGITAL_PIN(FIRST_DIGITAL_PIN),
        .CFG_SELECT0(CFG_SELECT0), .CFG_SELECT1(CFG_SELECT1),
        .PIN_GPIO_MODE(PIN_GPIO_MODE), .PIN_MAP_COMBINED(PIN_MAP_COMBINED));

    usf_partner usf_partner_i (
        .clk(SYS_CLK), .txd(TXD), .rxd(RXD), .per(16'h0004), .nbits(nbits));

    // ====================
    // Bus and compare tasks
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        PSEL    <= 1'b1;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        do @(posedge SYS_CLK); while (PREADY !== 1'b1);
        rd  = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic wait_cap;
        while (usf_partner_i.ncap == n0) @(posedge SYS_CLK);
    endtask

    // One frame in format c
    task automatic txf(input logic [9:0] c, input logic [7:0] d);
        logic [7:0]  dm;
        logic [11:0] e, m;
        logic        hp, p;
        int          nb;
        nb = c[4] ? 8 : 7;
        dm = c[4] ? d : d & 8'h7f;
        hp = c[7:5] != 3'h0;
        p  = c[7:5] == 3'h1 ? ~^dm : c[7:5] == 3'h2 ? ^dm : c[7:5] == 3'h3;
        e  = {3'h0, dm, 1'b0};
        e[nb + 1] = hp ? p : 1'b1;
        e[nb + 2] = 1'b1;
        m  = (12'h1 << (nb + hp + 2)) - 12'h1;
        nbits <= 4'(nb + hp);
        bus(1'b1, ADDR_CTRL, 32'(c));
        n0 = usf_partner_i.ncap;
        bus(1'b1, ADDR_TXDATA, 32'(d));
        wait_cap();
        chk(32'(usf_partner_i.got & m), 32'(e & m));
        repeat (8) @(posedge SYS_CLK);
    endtask

    task automatic finish_test;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ====================
    // Watchdog
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        err_total++;
        finish_test();
    end

    // ====================
    // Test sequence
    initial begin
        repeat (20) @(posedge SYS_CLK);
        RST <= 1'b0;
        rc(ADDR_CTRL, 32'(CTRL_RESET));
        rc(ADDR_BAUD, 32'(BAUD_RESET));
        rc(ADDR_XCHAR, 32'(XCHAR_RESET));
        rc(8'h18, 32'h0);
        chk(32'(err), 32'h1);
        bus(1'b1, ADDR_BAUD, 32'h20);
        for (int k = 0; k < 7; k++) txf(fr[k], 8'ha6 + 8'(k));
        nbits <= 4'h8;
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, ADDR_CTRL, 32'h213 + 32'(2 * k));
            if (k == 2) usf_partner_i.send(9'h13, 8);
            n0 = usf_partner_i.ncap;
            bus(1'b1, ADDR_TXDATA, 32'h3c);
            repeat (60) @(posedge SYS_CLK);
            chk(32'(usf_partner_i.ncap - n0) | 32'(FIRST_DIGITAL_PIN), 32'h0);
            if (k == 2) usf_partner_i.send(9'h11, 8);
            else {SET_READY_N, CLEAR_TO_SEND_N} <= k ? 2'b01 : 2'b10;
            wait_cap();
            chk(32'(usf_partner_i.got[9:0]), 32'h278);
            {SET_READY_N, CLEAR_TO_SEND_N} <= 2'b11;
        end
        bus(1'b1, ADDR_CTRL, 32'h213);
        usf_partner_i.send(9'h5a, 8);
        usf_partner_i.send(9'hc3, 8);
        repeat (8) @(posedge SYS_CLK);
        chk(32'(REQUEST_TO_SEND_N), 32'h1);
        rc(ADDR_RXDATA, 32'h15a);
        repeat (3) @(posedge SYS_CLK);
        chk(32'(REQUEST_TO_SEND_N), 32'h0);
        rc(ADDR_RXDATA, 32'h1c3);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(32'(rd[11:10]), 32'h1);
        bus(1'b1, ADDR_CTRL, 32'h019);
        repeat (2) @(posedge SYS_CLK);
        chk(32'(TERMINAL_READY_N), 32'h1);
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, ADDR_CTRL, k ? 32'h211 : 32'h218);
            repeat (2) @(posedge SYS_CLK);
            chk({PIN_GPIO_MODE, TXD, REQUEST_TO_SEND_N}, 32'h7);
        end
        bus(1'b1, ADDR_CTRL, 32'h219);
        for (int v = 1; v < 4; v++) begin
            {CFG_SELECT1, CFG_SELECT0} <= 2'(v);
            repeat (6) @(posedge SYS_CLK);
            chk({PIN_GPIO_MODE, PIN_MAP_COMBINED}, {v == 1, v == 3});
        end
        finish_test();
    end
endmodule
